// ---- inc/dpm_pkg.sv ----
// constants, types and helper functions shared by the mailbox block
package dpm_pkg;

    localparam int DPM_NMBX = 4;
    localparam int DPM_NWORD = 8;
    localparam int DPM_NBYTE = 4;

    // word index of each register, same map on both sides
    localparam logic [5:0] DPM_IDX_OUT = 6'h00;
    localparam logic [5:0] DPM_IDX_IN = 6'h04;
    localparam logic [5:0] DPM_IDX_FLAGS = 6'h08;
    localparam logic [5:0] DPM_IDX_CTRL = 6'h09;
    localparam logic [5:0] DPM_IDX_ISEL = 6'h0a;
    localparam logic [5:0] DPM_IDX_ISTAT = 6'h0b;
    localparam logic [5:0] DPM_IDX_ICLR = 6'h0c;
    localparam logic [5:0] DPM_IDX_IEN = 6'h0d;

    // control register: write one to clear every flag
    localparam int DPM_CTRL_FRST_BIT = 0;

    // interrupt select fields
    localparam int DPM_ISEL_OMB_LSB = 0;
    localparam int DPM_ISEL_OBY_LSB = 2;
    localparam int DPM_ISEL_IMB_LSB = 4;
    localparam int DPM_ISEL_IBY_LSB = 6;

    // interrupt status, clear and enable bits
    localparam int DPM_IRQ_IN_BIT = 0;
    localparam int DPM_IRQ_OUT_BIT = 1;

    localparam logic [7:0] DPM_ISEL_RST = 8'h00;
    localparam logic [1:0] DPM_IEN_RST = 2'h0;
    localparam logic [1:0] DPM_ISTAT_RST = 2'h0;
    localparam logic [15:0] DPM_FLAGS_RST = 16'h0000;
    localparam logic [31:0] DPM_DATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {DPM_IDLE, DPM_FETCH, DPM_DONE} dpm_ph_type;

    // flag mask of the enabled bytes of one mailbox
    function automatic logic [15:0] dpm_byte_mask(input logic [1:0] mbx,
                                                  input logic [3:0] be);
        dpm_byte_mask = {12'h000, be} << {mbx, 2'b00};
    endfunction

    // one flag picked by mailbox and byte number
    function automatic logic dpm_flag_pick(input logic [15:0] flags,
                                           input logic [1:0] mbx,
                                           input logic [1:0] byt);
        dpm_flag_pick = flags[{mbx, byt}];
    endfunction

endpackage

// ---- verilog/dpm_mbx_mem.sv ----
// eight shared mailbox words with two write ports and latched reads
`timescale 1ns/100ps
module dpm_mbx_mem
    import dpm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic a_we,
    input wire logic [1:0] a_waddr,
    input wire logic [3:0] a_be,
    input wire logic [31:0] a_wdata,
    input wire logic a_re,
    input wire logic [2:0] a_raddr,
    output logic [31:0] a_rdata,
    input wire logic b_we,
    input wire logic [1:0] b_waddr,
    input wire logic [3:0] b_be,
    input wire logic [31:0] b_wdata,
    input wire logic b_re,
    input wire logic [2:0] b_raddr,
    output logic [31:0] b_rdata
);
    logic [31:0] word_q [DPM_NWORD];

    // port a owns words 0..3, port b owns words 4..7
    for (genvar gw = 0; gw < DPM_NWORD; gw++) begin : g_word
        localparam logic [2:0] WA = 3'(gw);
        wire logic [3:0] lane_we;
        wire logic [31:0] lane_wd;
        assign lane_we = WA[2] ?
            ((b_we && b_waddr == WA[1:0]) ? b_be : 4'h0) :
            ((a_we && a_waddr == WA[1:0]) ? a_be : 4'h0);
        assign lane_wd = WA[2] ? b_wdata : a_wdata;
        for (genvar gb = 0; gb < DPM_NBYTE; gb++) begin : g_byte
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    word_q[gw][gb*8 +: 8] <= 8'h00;
                end else if (lane_we[gb]) begin
                    word_q[gw][gb*8 +: 8] <= lane_wd[gb*8 +: 8];
                end
            end
        end
    end

    // read data held in its own register until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_rdata <= DPM_DATA_RST;
            b_rdata <= DPM_DATA_RST;
        end else begin
            if (a_re) begin
                a_rdata <= word_q[a_raddr];
            end
            if (b_re) begin
                b_rdata <= word_q[b_raddr];
            end
        end
    end
endmodule // dpm_mbx_mem

// ---- verilog/dpm_irq_src.sv ----
// one side's mailbox interrupt: select, enable, sticky status, line
`timescale 1ns/100ps
module dpm_irq_src
    import dpm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] out_flags_q,
    input wire logic [15:0] out_flags_d,
    input wire logic [15:0] in_flags_q,
    input wire logic [15:0] in_flags_d,
    input wire logic [7:0] wdata,
    input wire logic sel_we,
    input wire logic en_we,
    input wire logic clr_we,
    output logic [7:0] sel_q,
    output logic [1:0] en_q,
    output logic [1:0] stat_q,
    output logic irq_q
);
    wire logic [1:0] omb = sel_q[DPM_ISEL_OMB_LSB +: 2];
    wire logic [1:0] oby = sel_q[DPM_ISEL_OBY_LSB +: 2];
    wire logic [1:0] imb = sel_q[DPM_ISEL_IMB_LSB +: 2];
    wire logic [1:0] iby = sel_q[DPM_ISEL_IBY_LSB +: 2];
    wire logic out_now = dpm_flag_pick(out_flags_q, omb, oby);
    wire logic out_nxt = dpm_flag_pick(out_flags_d, omb, oby);
    wire logic in_now = dpm_flag_pick(in_flags_q, imb, iby);
    wire logic in_nxt = dpm_flag_pick(in_flags_d, imb, iby);
    wire logic [1:0] ev;
    wire logic [1:0] clr;
    wire logic [1:0] stat_d;

    // selected incoming byte becomes full, outgoing byte becomes empty
    assign ev[DPM_IRQ_IN_BIT] = !in_now && in_nxt;
    assign ev[DPM_IRQ_OUT_BIT] = out_now && !out_nxt;
    assign clr = clr_we ? wdata[1:0] : 2'h0;
    assign stat_d = ev | (stat_q & ~clr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= DPM_ISEL_RST;
            en_q <= DPM_IEN_RST;
            stat_q <= DPM_ISTAT_RST;
            irq_q <= 1'b0;
        end else begin
            sel_q <= sel_we ? wdata : sel_q;
            en_q <= en_we ? wdata[1:0] : en_q;
            stat_q <= stat_d;
            irq_q <= |(stat_q & en_q);
        end
    end
endmodule // dpm_irq_src

// ---- verilog/dpm_mailbox.sv ----
// mailbox block: apb host side, local bus side, byte flags, interrupts
//
// Operation
// - eight 32-bit mailboxes, four each way
// - host incoming shares storage with local outgoing
// - local incoming shares storage with host outgoing
// - one incoming, one outgoing interrupt source per side
// - local incoming reads come through a holding latch
// - host incoming reads come through a holding latch
// - per-byte full flag in each side's status
// - write sets flags only for enabled bytes
// - write fills peer mailbox and both status views
// - incoming flags mirror the peer's outgoing flags
// - reading bytes clears their flags, only per-flag way
// - status registers read-only, writes ignored
// - control bit on each side clears all flags
// - one data phase per host access
// - overwrite when full, old data when empty, no error
// - host interrupt follows the completing local access
// - local interrupt follows host access, drops on clear
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module dpm_mailbox
    import dpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic local_sel,
    input wire logic local_wr,
    input wire logic [3:0] local_addr,
    input wire logic [3:0] local_be,
    input wire logic [31:0] local_wdata,
    output logic [31:0] local_rdata,
    output logic local_ack,
    output logic host_interrupt_line,
    output logic local_irq
);

    // host side bus state
    dpm_ph_type hph_q;
    dpm_ph_type hph_d;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // local side bus state
    dpm_ph_type lph_q;
    dpm_ph_type lph_d;
    logic local_ack_q;
    logic [31:0] local_rdata_q;

    // flags of words 0..3 (host to local) and 4..7 (local to host)
    logic [15:0] h2l_q;
    logic [15:0] h2l_d;
    logic [15:0] l2h_q;
    logic [15:0] l2h_d;

    // mailbox storage read data
    logic [31:0] mem_rdata_a;
    logic [31:0] mem_rdata_b;

    // interrupt register views
    logic [7:0] h_sel;
    logic [1:0] h_en;
    logic [1:0] h_stat;
    logic h_irq;
    logic [7:0] l_sel;
    logic [1:0] l_en;
    logic [1:0] l_stat;
    logic l_irq;

    // ---------------- host side decode ----------------
    wire logic [5:0] h_idx = paddr[7:2];
    wire logic h_map;
    wire logic h_setup;
    wire logic h_done;
    wire logic h_wr;
    wire logic h_rd;
    wire logic h_wr_out;
    wire logic h_rd_in;
    wire logic [31:0] h_rdata;

    assign h_map = (paddr[1:0] == 2'b00) && (h_idx <= DPM_IDX_IEN);
    assign h_setup = (hph_q == DPM_IDLE) && psel && !penable;
    // the access completes on the edge that sees pready high
    assign h_done = (hph_q == DPM_DONE) && psel && penable;
    assign h_wr = h_done && pwrite && h_map;
    assign h_rd = h_done && !pwrite && h_map;
    assign h_wr_out = h_wr && (h_idx[5:2] == DPM_IDX_OUT[5:2]);
    assign h_rd_in = h_rd && (h_idx[5:2] == DPM_IDX_IN[5:2]);

    // host word index equals storage word index
    assign h_rdata =
        (h_idx < DPM_IDX_FLAGS) ? mem_rdata_a :
        (h_idx == DPM_IDX_FLAGS) ? {l2h_q, h2l_q} :
        (h_idx == DPM_IDX_ISEL) ? {24'h000000, h_sel} :
        (h_idx == DPM_IDX_ISTAT) ? {30'h0, h_stat} :
        (h_idx == DPM_IDX_IEN) ? {30'h0, h_en} :
        32'h0000_0000;

    // ---------------- local side decode ----------------
    wire logic [5:0] l_idx = {2'b00, local_addr};
    wire logic l_map;
    wire logic l_start;
    wire logic l_done;
    wire logic l_wr;
    wire logic l_rd;
    wire logic l_wr_out;
    wire logic l_rd_in;
    wire logic [2:0] l_word;
    wire logic [31:0] l_rdata;

    assign l_map = (l_idx <= DPM_IDX_IEN);
    assign l_start = (lph_q == DPM_IDLE) && local_sel;
    assign l_done = (lph_q == DPM_FETCH);
    assign l_wr = l_done && local_wr && l_map;
    assign l_rd = l_done && !local_wr && l_map;
    assign l_wr_out = l_wr && (l_idx[5:2] == DPM_IDX_OUT[5:2]);
    assign l_rd_in = l_rd && (l_idx[5:2] == DPM_IDX_IN[5:2]);
    // local outgoing 0..3 are words 4..7, incoming 0..3 are words 0..3
    assign l_word = {~l_idx[2], l_idx[1:0]};

    assign l_rdata =
        (l_idx < DPM_IDX_FLAGS) ? mem_rdata_b :
        (l_idx == DPM_IDX_FLAGS) ? {h2l_q, l2h_q} :
        (l_idx == DPM_IDX_ISEL) ? {24'h000000, l_sel} :
        (l_idx == DPM_IDX_ISTAT) ? {30'h0, l_stat} :
        (l_idx == DPM_IDX_IEN) ? {30'h0, l_en} :
        32'h0000_0000;

    // ---------------- mailbox storage ----------------
    // a full mailbox is simply overwritten, an empty one reads old data
    dpm_mbx_mem u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .a_we(h_wr_out),
        .a_waddr(h_idx[1:0]),
        .a_be(pstrb),
        .a_wdata(pwdata),
        .a_re(h_setup),
        .a_raddr(h_idx[2:0]),
        .a_rdata(mem_rdata_a),
        .b_we(l_wr_out),
        .b_waddr(l_idx[1:0]),
        .b_be(local_be),
        .b_wdata(local_wdata),
        .b_re(l_start),
        .b_raddr(l_word),
        .b_rdata(mem_rdata_b)
    );

    // ---------------- empty/full flags ----------------
    wire logic g_clr;
    wire logic [15:0] h2l_set;
    wire logic [15:0] h2l_clr;
    wire logic [15:0] l2h_set;
    wire logic [15:0] l2h_clr;

    // either side's control bit clears every flag
    assign g_clr =
        (h_wr && h_idx == DPM_IDX_CTRL && pwdata[DPM_CTRL_FRST_BIT]) ||
        (l_wr && l_idx == DPM_IDX_CTRL &&
         local_wdata[DPM_CTRL_FRST_BIT]);

    // writes mark only the bytes that were enabled
    assign h2l_set = h_wr_out ?
        dpm_byte_mask(h_idx[1:0], pstrb) : 16'h0000;
    assign l2h_set = l_wr_out ?
        dpm_byte_mask(l_idx[1:0], local_be) : 16'h0000;

    // reads of incoming bytes are the only per-flag clear
    assign l2h_clr = h_rd_in ?
        dpm_byte_mask(h_idx[1:0], 4'hf) : 16'h0000;
    assign h2l_clr = l_rd_in ?
        dpm_byte_mask(l_idx[1:0], local_be) : 16'h0000;

    // global clear first, then a set beats a same-cycle read clear
    assign h2l_d = g_clr ? DPM_FLAGS_RST :
        ((h2l_q & ~h2l_clr) | h2l_set);
    assign l2h_d = g_clr ? DPM_FLAGS_RST :
        ((l2h_q & ~l2h_clr) | l2h_set);

    // one flag store serves both status views, writes to them ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h2l_q <= DPM_FLAGS_RST;
            l2h_q <= DPM_FLAGS_RST;
        end else begin
            h2l_q <= h2l_d;
            l2h_q <= l2h_d;
        end
    end

    // ---------------- interrupts ----------------
    // host sees its outgoing as words 0..3 and incoming as 4..7
    dpm_irq_src u_host_irq (
        .clk(pclk),
        .rst_n(presetn),
        .out_flags_q(h2l_q),
        .out_flags_d(h2l_d),
        .in_flags_q(l2h_q),
        .in_flags_d(l2h_d),
        .wdata(pwdata[7:0]),
        .sel_we(h_wr && h_idx == DPM_IDX_ISEL),
        .en_we(h_wr && h_idx == DPM_IDX_IEN),
        .clr_we(h_wr && h_idx == DPM_IDX_ICLR),
        .sel_q(h_sel),
        .en_q(h_en),
        .stat_q(h_stat),
        .irq_q(h_irq)
    );

    dpm_irq_src u_local_irq (
        .clk(pclk),
        .rst_n(presetn),
        .out_flags_q(l2h_q),
        .out_flags_d(l2h_d),
        .in_flags_q(h2l_q),
        .in_flags_d(h2l_d),
        .wdata(local_wdata[7:0]),
        .sel_we(l_wr && l_idx == DPM_IDX_ISEL),
        .en_we(l_wr && l_idx == DPM_IDX_IEN),
        .clr_we(l_wr && l_idx == DPM_IDX_ICLR),
        .sel_q(l_sel),
        .en_q(l_en),
        .stat_q(l_stat),
        .irq_q(l_irq)
    );

    assign host_interrupt_line = h_irq;
    assign local_irq = l_irq;

    // ---------------- host apb sequencing ----------------
    // setup latches storage, next edge loads prdata and raises pready
    always_comb begin
        hph_d = hph_q;
        unique case (hph_q)
            DPM_IDLE: begin
                if (h_setup) begin
                    hph_d = DPM_FETCH;
                end
            end
            DPM_FETCH: begin
                hph_d = DPM_DONE;
            end
            DPM_DONE: begin
                if (h_done) begin
                    hph_d = DPM_IDLE;
                end
            end
            default: begin
                hph_d = DPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hph_q <= DPM_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= DPM_DATA_RST;
        end else begin
            hph_q <= hph_d;
            pready_q <= (hph_q == DPM_FETCH);
            if (hph_q == DPM_FETCH) begin
                prdata_q <= pwrite ? DPM_DATA_RST : h_rdata;
                pslverr_q <= !h_map;
            end else if (h_done) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ---------------- local bus sequencing ----------------
    // start latches storage, next edge commits and pulses ack
    always_comb begin
        lph_d = lph_q;
        unique case (lph_q)
            DPM_IDLE: begin
                if (l_start) begin
                    lph_d = DPM_FETCH;
                end
            end
            DPM_FETCH: begin
                lph_d = DPM_DONE;
            end
            DPM_DONE: begin
                lph_d = DPM_IDLE;
            end
            default: begin
                lph_d = DPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lph_q <= DPM_IDLE;
            local_ack_q <= 1'b0;
            local_rdata_q <= DPM_DATA_RST;
        end else begin
            lph_q <= lph_d;
            local_ack_q <= l_done;
            if (l_done) begin
                local_rdata_q <= local_wr ? DPM_DATA_RST : l_rdata;
            end
        end
    end

    assign local_rdata = local_rdata_q;
    assign local_ack = local_ack_q;

endmodule // dpm_mailbox

// ---- verif/dpm_mailbox_assertions.sv ----
// concurrent checks on the mailbox block ports
`timescale 1ns/100ps
module dpm_mailbox_assertions
    import dpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic local_sel,
    input wire logic local_wr,
    input wire logic [3:0] local_addr,
    input wire logic [3:0] local_be,
    input wire logic [31:0] local_wdata,
    input wire logic [31:0] local_rdata,
    input wire logic local_ack,
    input wire logic host_interrupt_line,
    input wire logic local_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire host_clr = psel && penable && pready && pwrite && !local_sel &&
        paddr == {DPM_IDX_ICLR, 2'b00} && pwdata[1:0] == 2'h3;
    wire local_clr = local_ack && local_sel && local_wr && !psel &&
        local_addr == DPM_IDX_ICLR[3:0] && local_wdata[1:0] == 2'h3;

    // one idle cycle, then the answer
    sequence late_answer(s);
        !s ##1 s;
    endsequence

    apb_answer_a: assert property (
        psel && !penable |=> late_answer(pready))
        else $error("apb answer late or early");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    no_error_a: assert property (pready && paddr[1:0] == 2'h0 &&
        paddr[7:2] <= DPM_IDX_IEN |-> !pslverr)
        else $error("mapped access flagged as error");
    ack_timing_a: assert property (
        $rose(local_sel) |=> late_answer(local_ack))
        else $error("local ack not in second cycle");
    ack_pulse_a: assert property (local_ack |=> !local_ack)
        else $error("local ack longer than one cycle");
    // apb commits as pready is sampled, so a line lags pready by two
    host_rise_a: assert property ($rose(host_interrupt_line) |->
        $past(local_ack) || $past(pready, 2))
        else $error("host interrupt without access");
    host_drop_a: assert property (
        host_clr |=> ##1 !host_interrupt_line)
        else $error("host interrupt not dropped after clear");
    local_rise_a: assert property ($rose(local_irq) |->
        $past(pready, 2) || $past(local_ack))
        else $error("local interrupt without access");
    local_drop_a: assert property (local_clr |=> !local_irq)
        else $error("local interrupt not dropped after clear");
endmodule // dpm_mailbox_assertions

bind dpm_mailbox dpm_mailbox_assertions i_dpm_mailbox_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .local_sel(local_sel), .local_wr(local_wr), .local_addr(local_addr),
    .local_be(local_be), .local_wdata(local_wdata),
    .local_rdata(local_rdata), .local_ack(local_ack),
    .host_interrupt_line(host_interrupt_line), .local_irq(local_irq));

// ---- verif/dpm_local_master.sv ----
// local bus master model for the mailbox block's local side
`timescale 1ns/100ps
module dpm_local_master
    import dpm_pkg::*;
(
    input wire logic pclk,
    input wire logic [31:0] local_rdata,
    input wire logic local_ack,
    output logic local_sel,
    output logic local_wr,
    output logic [3:0] local_addr,
    output logic [3:0] local_be,
    output logic [31:0] local_wdata
);
    initial begin
        local_sel = 1'b0;
        local_wr = 1'b0;
        local_addr = 4'h0;
        local_be = 4'h0;
        local_wdata = 32'h0000_0000;
    end

    // gap plus one idle cycles first, to model a slow master
    task automatic xfer(input logic wr, input logic [3:0] addr,
                        input logic [3:0] be, input logic [31:0] wd,
                        input int gap, output logic [31:0] rd,
                        output logic ok);
        repeat (gap + 1) @(posedge pclk);
        local_sel <= 1'b1;
        local_wr <= wr;
        local_addr <= addr;
        local_be <= be;
        local_wdata <= wd;
        do begin
            @(posedge pclk);
        end while (local_ack !== 1'b1);
        rd = local_rdata;
        ok = local_ack;
        local_sel <= 1'b0;
        local_be <= ~be;
        // released bus must not keep showing the last data
        local_wdata <= ~wd;
    endtask
endmodule // dpm_local_master

// ---- verif/dpm_mailbox_tb_top.sv ----
// self-checking bench for the mailbox block
`timescale 1ns/100ps
module dpm_mailbox_tb_top
    import dpm_pkg::*;
();
    localparam logic [5:0] ZIDX [7] = '{DPM_IDX_FLAGS, DPM_IDX_ISEL,
        DPM_IDX_ISTAT, DPM_IDX_IEN, DPM_IDX_IN, DPM_IDX_CTRL, DPM_IDX_ICLR};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, local_rdata, local_wdata, rd, spare;
    logic pready, pslverr, local_sel, local_wr, local_ack;
    logic host_interrupt_line, local_irq, err, lok;
    logic [3:0] local_addr, local_be;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    initial forever #2.5 pclk = ~pclk;

    dpm_mailbox i_dpm_mailbox (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_sel(local_sel), .local_wr(local_wr), .local_addr(local_addr),
        .local_be(local_be), .local_wdata(local_wdata),
        .local_rdata(local_rdata), .local_ack(local_ack),
        .host_interrupt_line(host_interrupt_line), .local_irq(local_irq));
    dpm_local_master i_dpm_local_master (.pclk(pclk),
        .local_rdata(local_rdata), .local_ack(local_ack),
        .local_sel(local_sel), .local_wr(local_wr), .local_addr(local_addr),
        .local_be(local_be), .local_wdata(local_wdata));

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [31:0] wd, input logic [3:0] st);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd;
    endtask

    task automatic lb(input logic wr, input logic [5:0] idx,
                      input logic [3:0] be, input logic [31:0] wd);
        i_dpm_local_master.xfer(wr, idx[3:0], be, wd, 0, rd, lok);
    endtask

    task automatic settle;
        repeat (2) @(posedge pclk);
    endtask

    task automatic t_reset;
        foreach (ZIDX[i]) begin
            apb(1'b0, ZIDX[i], 32'h0, 4'h0);
            chk_word("host reset value", 32'h0, rd);
            lb(1'b0, ZIDX[i], 4'hf, 32'h0);
            chk_word("local reset value", 32'h0, rd);
        end
    endtask

    task automatic t_host_to_local;
        apb(1'b1, DPM_IDX_OUT + 6'h1, 32'ha1b2_c3d4, 4'h3);
        chk_bit("host err", 1'b0, err);
        apb(1'b0, DPM_IDX_FLAGS, 32'h0, 4'h0);
        chk_word("host flags", 32'h0000_0030, rd);
        lb(1'b0, DPM_IDX_FLAGS, 4'hf, 32'h0);
        chk_word("local flags", 32'h0030_0000, rd);
        lb(1'b0, DPM_IDX_IN + 6'h1, 4'h1, 32'h0);
        chk_word("local in 2", 32'h0000_c3d4, rd);
        apb(1'b0, DPM_IDX_FLAGS, 32'h0, 4'h0);
        chk_word("host flags part read", 32'h0000_0020, rd);
        lb(1'b0, DPM_IDX_IN + 6'h1, 4'h2, 32'h0);
        lb(1'b0, DPM_IDX_IN + 6'h1, 4'h2, 32'h0);
        chk_word("local in 2 empty", 32'h0000_c3d4, rd);
        lb(1'b0, DPM_IDX_FLAGS, 4'hf, 32'h0);
        chk_word("local flags read", 32'h0, rd);
    endtask

    task automatic t_local_to_host;
        lb(1'b1, DPM_IDX_OUT + 6'h2, 4'hf, 32'h1111_2222);
        lb(1'b1, DPM_IDX_OUT + 6'h2, 4'hf, 32'h5566_7788);
        apb(1'b1, DPM_IDX_FLAGS, 32'h0, 4'hf);
        lb(1'b1, DPM_IDX_FLAGS, 4'hf, 32'hffff_ffff);
        apb(1'b0, DPM_IDX_FLAGS, 32'h0, 4'h0);
        chk_word("host flags", 32'h0f00_0000, rd);
        lb(1'b0, DPM_IDX_FLAGS, 4'hf, 32'h0);
        chk_word("local flags", 32'h0000_0f00, rd);
        apb(1'b0, DPM_IDX_IN + 6'h2, 32'h0, 4'h0);
        chk_word("host in 3", 32'h5566_7788, rd);
        apb(1'b0, DPM_IDX_FLAGS, 32'h0, 4'h0);
        chk_word("host flags read", 32'h0, rd);
        apb(1'b0, 6'h0e, 32'h0, 4'h0);
        chk_bit("unmapped err", 1'b1, err);
    endtask

    task automatic t_global_clear;
        apb(1'b1, DPM_IDX_OUT, 32'h0102_0304, 4'hf);
        lb(1'b1, DPM_IDX_OUT, 4'hf, 32'h0506_0708);
        apb(1'b1, DPM_IDX_CTRL, 32'h1, 4'hf);
        apb(1'b0, DPM_IDX_FLAGS, 32'h0, 4'h0);
        chk_word("flags host clear", 32'h0, rd);
        apb(1'b1, DPM_IDX_OUT, 32'h0102_0304, 4'hf);
        lb(1'b1, DPM_IDX_CTRL, 4'hf, 32'h1);
        lb(1'b0, DPM_IDX_FLAGS, 4'hf, 32'h0);
        chk_word("flags local clear", 32'h0, rd);
        fork
            apb(1'b1, DPM_IDX_CTRL, 32'h1, 4'hf);
            i_dpm_local_master.xfer(1'b1, 4'h1, 4'hf, 32'h9, 1, spare, lok);
        join
        apb(1'b0, DPM_IDX_FLAGS, 32'h0, 4'h0);
        chk_word("flags clear wins", 32'h0, rd);
    endtask

    task automatic t_host_irq;
        apb(1'b1, DPM_IDX_ICLR, 32'h3, 4'hf);
        apb(1'b1, DPM_IDX_ISEL, 32'h0000_000d, 4'hf);
        lb(1'b1, DPM_IDX_OUT, 4'h1, 32'h0000_00aa);
        apb(1'b0, DPM_IDX_ISTAT, 32'h0, 4'h0);
        chk_word("host status in", 32'h1, rd);
        chk_bit("host line masked", 1'b0, host_interrupt_line);
        apb(1'b1, DPM_IDX_IEN, 32'h3, 4'hf);
        settle();
        chk_bit("host line on", 1'b1, host_interrupt_line);
        apb(1'b1, DPM_IDX_ICLR, 32'h3, 4'hf);
        settle();
        chk_bit("host line off", 1'b0, host_interrupt_line);
        apb(1'b1, DPM_IDX_OUT + 6'h1, 32'h5500_0000, 4'h8);
        lb(1'b0, DPM_IDX_IN + 6'h1, 4'h8, 32'h0);
        settle();
        chk_bit("host line empty", 1'b1, host_interrupt_line);
        apb(1'b0, DPM_IDX_ISTAT, 32'h0, 4'h0);
        chk_word("host status out", 32'h2, rd);
        apb(1'b1, DPM_IDX_ICLR, 32'h3, 4'hf);
    endtask

    task automatic t_local_irq;
        lb(1'b1, DPM_IDX_ICLR, 4'hf, 32'h3);
        lb(1'b1, DPM_IDX_ISEL, 4'hf, 32'h0000_00b0);
        lb(1'b1, DPM_IDX_IEN, 4'hf, 32'h1);
        apb(1'b1, DPM_IDX_OUT + 6'h3, 32'h00ee_0000, 4'h4);
        settle();
        chk_bit("local line on", 1'b1, local_irq);
        lb(1'b0, DPM_IDX_ISTAT, 4'hf, 32'h0);
        chk_word("local status", 32'h1, rd);
        lb(1'b1, DPM_IDX_ICLR, 4'hf, 32'h3);
        settle();
        chk_bit("local line off", 1'b0, local_irq);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_host_to_local();
        t_local_to_host();
        t_global_clear();
        t_host_irq();
        t_local_irq();
        conclude();
    end
endmodule // dpm_mailbox_tb_top
